/* hdl/adc_seq_pkg.sv */
package adc_seq_pkg;
	localparam int NUM_CH = 16;
	localparam int CH_W = 4;
	localparam int WORD_W = 16;
	localparam int CTRL_W = 12;
	localparam int RESULT_W = 12;
	// Control word bit positions
	localparam int WRITE_POS = 11;
	localparam int CYCLE_POS = 10;
	localparam int ADDR_HI = 9;
	localparam int ADDR_LO = 6;
	localparam int PM_HI = 5;
	localparam int PM_LO = 4;
	localparam int MASKSEL_POS = 3;
	localparam int WEAK_POS = 2;
	localparam int RANGE_POS = 1;
	localparam int CODING_POS = 0;
	// Reset values, and FALL_LAST as the falling-edge count of a full word
	localparam logic [10:0] CTRL_RESET = 11'h000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [3:0] CH_RESET = 4'h0;
	localparam logic [4:0] FALL_LAST = 5'h10;
	typedef enum logic [3:0] {
		MODE_SINGLE = 4'h1,
		MODE_MASKLOAD = 4'h2,
		MODE_MASKRUN = 4'h4,
		MODE_CONSEC = 4'h8
	} seq_mode_t;
	typedef struct packed {
		logic autoCycle;
		logic [3:0] channelAddressBits;
		logic [1:0] powerMode;
		logic maskSelect;
		logic weakDrive;
		logic rangeSingleRef;
		logic codingBinary;
	} ctrl_t;
endpackage

/* hdl/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1,
	// Idle level of each pin, so an edge detector sees no false edge after reset
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinOut
);
	logic [W-1:0] stage1_q;
	logic [W-1:0] stage2_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			stage1_q <= RST_VAL;
			stage2_q <= RST_VAL;
		end else begin
			stage1_q <= pinIn;
			stage2_q <= stage1_q;
		end
	end
	assign pinOut = stage2_q;
endmodule // pin_sync

/* hdl/adc_channel_sequencer.sv */
`timescale 1ns/100ps
// Summary of operation
// - Modes 00: channel from previous write
// - Modes 01: next write loads mask
// - Mask any set; advance per frame
// - Modes 10: keep sequence, take other bits
// - Modes 11: channels 0 up to address
// - Mask register 16 bits, write-only
// - Mask shifted in over 16 falling edges
// - Mask captured only after 01 write
// - First bit is channel 0, bit 15
// - Ascending until write with non-10 modes
// - Consecutive mode runs without writes
// - Control bit 1 selects input range
// - Serial clock shifts and converts
// - Control loads only if bit 11 set
// - Mode bits are control bits 10, 3
// - Wrap to first selected channel
// - Output word: address then 12 bits
module adc_channel_sequencer (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic chipSelect_b,
	input wire logic serialClock,
	input wire logic serialDataIn,
	input wire logic [adc_seq_pkg::RESULT_W-1:0] convResult,
	output logic serialDataOut,
	output logic serialDataOutEn,
	output logic [adc_seq_pkg::CH_W-1:0] muxChannel,
	output logic rangeSingleRef,
	output logic codingBinary,
	output logic [1:0] powerMode,
	output logic convStart,
	output logic sarStep,
	output adc_seq_pkg::seq_mode_t seqMode
);
	localparam int NCH = adc_seq_pkg::NUM_CH;
	logic [2:0] pinSync;
	logic csSync;
	logic sclkSync;
	logic dinSync;
	logic csPrev_q;
	logic sclkPrev_q;
	// Pins cross from the host domain through two flops each
	// Chip select resets to its idle high level; a low reset value would fake a frame start
	pin_sync #(.W(3), .RST_VAL(3'h4)) uSync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pinIn({chipSelect_b, serialClock, serialDataIn}),
		.pinOut(pinSync)
	);
	assign csSync = pinSync[2];
	assign sclkSync = pinSync[1];
	assign dinSync = pinSync[0];

	wire frameStart = csPrev_q && !csSync;
	wire frameEnd = !csPrev_q && csSync;
	wire sclkFall = sclkPrev_q && !sclkSync && !csSync;
	wire sclkRise = !sclkPrev_q && sclkSync && !csSync;

	logic [adc_seq_pkg::WORD_W-1:0] shiftIn_q, shiftIn_d;
	logic [adc_seq_pkg::WORD_W-1:0] shiftOut_q, shiftOut_d;
	logic [4:0] fallCnt_q, fallCnt_d;
	adc_seq_pkg::ctrl_t ctrl_q, ctrl_d;
	logic [NCH-1:0] mask_q, mask_d;
	adc_seq_pkg::seq_mode_t mode_q, mode_d;
	logic [adc_seq_pkg::CH_W-1:0] chan_q, chan_d;
	logic [adc_seq_pkg::CH_W-1:0] convChan_q, convChan_d;
	logic dout_q, doutEn_q, convStart_q, sarStep_q;

	// Full word is taken when chip select rises after sixteen falling edges in the frame
	wire wordDone = frameEnd && (fallCnt_q == adc_seq_pkg::FALL_LAST);
	wire [adc_seq_pkg::CTRL_W-1:0] ctrlWord = shiftIn_q[adc_seq_pkg::WORD_W-1 -: adc_seq_pkg::CTRL_W];
	wire writeBit = ctrlWord[adc_seq_pkg::WRITE_POS];
	wire newCycle = ctrlWord[adc_seq_pkg::CYCLE_POS];
	wire newMaskSel = ctrlWord[adc_seq_pkg::MASKSEL_POS];
	wire [3:0] newAddr = ctrlWord[adc_seq_pkg::ADDR_HI:adc_seq_pkg::ADDR_LO];
	wire isMaskWord = (mode_q == adc_seq_pkg::MODE_MASKLOAD);
	wire ctrlWrite = wordDone && !isMaskWord && writeBit;
	// Mask arrives MSB first, so bit 15 is channel 0; reverse so index equals channel
	logic [NCH-1:0] maskByChan;
	always_comb begin
		maskByChan = '0;
		for (int i = 0; i < NCH; i++) begin
			maskByChan[i] = shiftIn_q[NCH-1-i];
		end
	end

	// Next channel in the mask strictly above cur, else lowest set bit
	function automatic logic [3:0] nextInMask(input logic [NCH-1:0] m, input logic [3:0] cur);
		logic [3:0] res;
		logic found;
		res = cur;
		found = 1'b0;
		for (int i = NCH-1; i >= 0; i--) begin
			if (m[i] && (i > int'(cur))) begin
				res = 4'(i);
				found = 1'b1;
			end
		end
		if (!found) begin
			for (int i = NCH-1; i >= 0; i--) begin
				if (m[i]) begin
					res = 4'(i);
				end
			end
		end
		return res;
	endfunction

	function automatic logic [3:0] firstInMask(input logic [NCH-1:0] m, input logic [3:0] cur);
		logic [3:0] res;
		res = cur;
		for (int i = NCH-1; i >= 0; i--) begin
			if (m[i]) begin
				res = 4'(i);
			end
		end
		return res;
	endfunction

	// Steps are taken from the channel actually converted, not the one queued
	wire [3:0] maskStep = nextInMask(mask_q, convChan_q);
	wire consecWrap = (convChan_q >= ctrl_q.channelAddressBits);
	wire [3:0] consecStep = consecWrap ? adc_seq_pkg::CH_RESET : convChan_q + 4'h1;
	wire [3:0] maskFirst = firstInMask(maskByChan, chan_q);

	// Frame kinds that end a complete word
	wire maskWordDone = wordDone && isMaskWord;
	wire idleWordDone = wordDone && !isMaskWord && !writeBit;

	// Next channel when a frame passes without a control write
	logic [3:0] runStep;
	always_comb begin
		unique case (mode_q)
			adc_seq_pkg::MODE_SINGLE: begin
				runStep = chan_q;
			end
			adc_seq_pkg::MODE_MASKLOAD: begin
				runStep = chan_q;
			end
			adc_seq_pkg::MODE_MASKRUN: begin
				runStep = maskStep;
			end
			adc_seq_pkg::MODE_CONSEC: begin
				runStep = consecStep;
			end
			default: begin
				runStep = chan_q;
			end
		endcase
	end

	// Next channel when a write keeps the running sequence
	logic [3:0] keepStep;
	always_comb begin
		unique case (mode_q)
			adc_seq_pkg::MODE_SINGLE: begin
				// Without a running sequence the write simply picks a new channel
				keepStep = newAddr;
			end
			adc_seq_pkg::MODE_MASKLOAD: begin
				keepStep = newAddr;
			end
			adc_seq_pkg::MODE_MASKRUN: begin
				keepStep = maskStep;
			end
			adc_seq_pkg::MODE_CONSEC: begin
				keepStep = consecStep;
			end
			default: begin
				keepStep = newAddr;
			end
		endcase
	end

	// Mode and channel chosen by a control write, from the two mode bits
	adc_seq_pkg::seq_mode_t writeMode;
	logic [3:0] writeChan;
	always_comb begin
		unique case ({newCycle, newMaskSel})
			2'h0: begin
				writeMode = adc_seq_pkg::MODE_SINGLE;
				writeChan = newAddr;
			end
			2'h1: begin
				writeMode = adc_seq_pkg::MODE_MASKLOAD;
				writeChan = newAddr;
			end
			2'h2: begin
				writeMode = mode_q;
				writeChan = keepStep;
			end
			2'h3: begin
				writeMode = adc_seq_pkg::MODE_CONSEC;
				writeChan = adc_seq_pkg::CH_RESET;
			end
		endcase
	end

	// Sequencer state and register updates at the end of a complete frame
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		mode_d = mode_q;
		chan_d = chan_q;
		if (maskWordDone) begin
			// Mask word: control register untouched, sequence begins at lowest selected channel
			mask_d = maskByChan;
			mode_d = adc_seq_pkg::MODE_MASKRUN;
			chan_d = maskFirst;
		end else if (ctrlWrite) begin
			ctrl_d = ctrlWord[10:0];
			mode_d = writeMode;
			chan_d = writeChan;
		end else if (idleWordDone) begin
			// No write: running sequences still advance
			chan_d = runStep;
		end
	end

	// Falls beyond the sixteenth are ignored, so an over-long frame cannot corrupt the word
	wire shiftNow = sclkFall && (fallCnt_q != adc_seq_pkg::FALL_LAST);
	wire [adc_seq_pkg::WORD_W-1:0] loadWord = {chan_q, convResult};

	// Serial shift: data in on falling edges, address then result out
	always_comb begin
		shiftIn_d = shiftIn_q;
		shiftOut_d = shiftOut_q;
		fallCnt_d = fallCnt_q;
		convChan_d = convChan_q;
		if (frameStart) begin
			fallCnt_d = 5'h00;
			convChan_d = chan_q;
			shiftOut_d = loadWord;
		end else if (shiftNow) begin
			shiftIn_d = {shiftIn_q[adc_seq_pkg::WORD_W-2:0], dinSync};
			shiftOut_d = {shiftOut_q[adc_seq_pkg::WORD_W-2:0], 1'b0};
			fallCnt_d = fallCnt_q + 5'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			csPrev_q <= 1'b1;
			sclkPrev_q <= 1'b0;
			shiftIn_q <= '0;
			shiftOut_q <= '0;
			fallCnt_q <= 5'h00;
			ctrl_q <= adc_seq_pkg::CTRL_RESET;
			mask_q <= adc_seq_pkg::MASK_RESET;
			mode_q <= adc_seq_pkg::MODE_SINGLE;
			chan_q <= adc_seq_pkg::CH_RESET;
			convChan_q <= adc_seq_pkg::CH_RESET;
		end else begin
			csPrev_q <= csSync;
			sclkPrev_q <= sclkSync;
			shiftIn_q <= shiftIn_d;
			shiftOut_q <= shiftOut_d;
			fallCnt_q <= fallCnt_d;
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			mode_q <= mode_d;
			chan_q <= chan_d;
			convChan_q <= convChan_d;
		end
	end

	// Output flops; mask has no read path, only its effect on the channel
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			dout_q <= 1'b0;
			doutEn_q <= 1'b0;
			convStart_q <= 1'b0;
			sarStep_q <= 1'b0;
		end else begin
			dout_q <= shiftOut_d[adc_seq_pkg::WORD_W-1];
			doutEn_q <= !csSync;
			convStart_q <= frameStart;
			sarStep_q <= sclkRise;
		end
	end

	assign serialDataOut = dout_q;
	assign serialDataOutEn = doutEn_q;
	assign muxChannel = convChan_q;
	assign rangeSingleRef = ctrl_q.rangeSingleRef;
	assign codingBinary = ctrl_q.codingBinary;
	assign powerMode = ctrl_q.powerMode;
	assign convStart = convStart_q;
	assign sarStep = sarStep_q;
	assign seqMode = mode_q;
endmodule // adc_channel_sequencer

/* testbench/adc_seq_chk.sv */
`timescale 1ns/100ps
module adc_seq_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic chipSelect_b,
	input wire logic serialDataOutEn,
	input wire logic [3:0] muxChannel,
	input wire logic rangeSingleRef,
	input wire logic convStart,
	input wire logic sarStep,
	input wire adc_seq_pkg::seq_mode_t seqMode
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	a_reset_state: assert property (disable iff (1'b0) !rst_b |=> seqMode == adc_seq_pkg::MODE_SINGLE)
		else $error("reset mode");
	a_mode_onehot: assert property ($onehot(seqMode))
		else $error("mode code");
	a_drive_idle: assert property (chipSelect_b [*4] |-> !serialDataOutEn)
		else $error("drive idle");
	a_drive_frame: assert property (!chipSelect_b [*4] |-> serialDataOutEn)
		else $error("drive frame");
	a_start_frame: assert property ($fell(chipSelect_b) |-> ##[1:6] convStart)
		else $error("no start");
	a_start_pulse: assert property (convStart |=> !convStart)
		else $error("start width");
	a_sar_pulse: assert property (sarStep |=> !sarStep)
		else $error("step width");
	// Updates land a few cycles after a frame edge, so only deep inside a frame is quiet
	a_hold_frame: assert property (!chipSelect_b [*8] |-> $stable({muxChannel, rangeSingleRef, seqMode}))
		else $error("changed mid-frame");
endmodule // adc_seq_chk
bind adc_channel_sequencer adc_seq_chk chk (.clk_sys, .rst_b, .chipSelect_b, .serialDataOutEn, .muxChannel,
	.rangeSingleRef, .convStart, .sarStep, .seqMode);

/* testbench/host_model.sv */
`timescale 1ns/100ps
module host_model (
	output logic chipSelect_b,
	output logic serialClock,
	output logic serialDataIn,
	input wire logic serialDataOut
);
	initial begin
		chipSelect_b = 1'b1;
		serialClock = 1'b1;
		serialDataIn = 1'b0;
	end
	// Short frames (n below 16) let the bench see partial words dropped
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		r = '0;
		chipSelect_b = 1'b0;
		#62.5;
		for (int i = 15; i > 15 - n; i--) begin
			serialDataIn = w[i];
			#31.25 r[i] = serialDataOut;
			serialClock = 1'b0;
			#62.5 serialClock = 1'b1;
			#31.25;
		end
		chipSelect_b = 1'b1;
		// Released data line must not look like a held bit
		serialDataIn = ~serialDataIn;
		#200;
	endtask
endmodule // host_model

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
	logic clk_sys, rst_b, chipSelect_b, serialClock, serialDataIn, serialDataOut, serialDataOutEn;
	logic rangeSingleRef, codingBinary, convStart, sarStep;
	logic [1:0] powerMode;
	logic [3:0] muxChannel, expCh, addr;
	logic [11:0] convResult, ctl;
	logic [15:0] mask, rd;
	adc_seq_pkg::seq_mode_t seqMode, mode;
	int miscompares = 0;
	int n_compared = 0;
	adc_channel_sequencer dut (.clk_sys, .rst_b, .chipSelect_b, .serialClock, .serialDataIn, .convResult,
		.serialDataOut, .serialDataOutEn, .muxChannel, .rangeSingleRef, .codingBinary, .powerMode,
		.convStart, .sarStep, .seqMode);
	host_model hm (.chipSelect_b, .serialClock, .serialDataIn, .serialDataOut);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [15:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [3:0] next_sel(input logic [3:0] c);
		logic [3:0] k;
		k = c;
		repeat (16) begin
			k = k + 4'h1;
			if (mask[~k]) return k;
		end
		return c;
	endfunction
	function automatic logic [15:0] mk(input logic [2:0] m, input logic [3:0] a);
		return {m[2], m[1], a, 2'($urandom), m[0], 7'($urandom)};
	endfunction
	task automatic frame(input logic [15:0] w, input int n = 16);
		@(negedge clk_sys);
		convResult = 12'($urandom);
		hm.xfer(w, n, rd);
		if (n < 16) return;
		if (mode != adc_seq_pkg::MODE_MASKLOAD) check(rd, {expCh, convResult});
		if (mode == adc_seq_pkg::MODE_MASKLOAD) begin
			mask = w;
			mode = adc_seq_pkg::MODE_MASKRUN;
			expCh = next_sel(4'hF);
		end else begin
			if (mode == adc_seq_pkg::MODE_MASKRUN) expCh = next_sel(expCh);
			if (mode == adc_seq_pkg::MODE_CONSEC) expCh = (expCh == addr) ? 4'h0 : expCh + 4'h1;
			if (w[15]) begin
				ctl = w[15:4];
				addr = w[13:10];
				if (!w[14] && !w[7]) mode = adc_seq_pkg::MODE_SINGLE;
				if (!w[14] && w[7]) mode = adc_seq_pkg::MODE_MASKLOAD;
				if (w[14] && w[7]) mode = adc_seq_pkg::MODE_CONSEC;
				if (mode == adc_seq_pkg::MODE_SINGLE) expCh = addr;
				if (w[14] && w[7]) expCh = 4'h0;
			end
		end
		check({12'h0, seqMode}, {12'h0, mode});
		check({12'h0, rangeSingleRef, codingBinary, powerMode}, {12'h0, ctl[1], ctl[0], ctl[5:4]});
	endtask
	task automatic give_verdict();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(54));
		{rst_b, convResult, ctl, mask, addr, expCh} = '0;
		mode = adc_seq_pkg::MODE_SINGLE;
		repeat (20) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (4) @(negedge clk_sys);
		check({8'h0, seqMode, muxChannel}, {8'h0, adc_seq_pkg::MODE_SINGLE, 4'h0});
		for (int i = 0; i < 16; i++) frame(mk(3'b100, 4'(i)));
		frame(mk(3'b100, 4'h5), 9);
		frame(mk(3'b011, 4'h3));
		frame(mk(3'b111, 4'h3));
		repeat (5) frame(mk(3'b000, 4'($urandom)));
		frame(mk(3'b110, 4'h3));
		frame(mk(3'b100, 4'h2));
		frame(mk(3'b101, 4'h9));
		frame(16'($urandom) | 16'h0001);
		repeat (12) frame(mk({1'b0, 2'($urandom)}, 4'($urandom)));
		frame(mk(3'b110, 4'($urandom)));
		repeat (4) frame(mk(3'b000, 4'h0));
		frame(mk(3'b100, 4'h7));
		frame(mk(3'b000, 4'h0));
		give_verdict();
	end
endmodule // tb
